/* src/mcb_map.svh */
// Constants of the multiport cable buffer: sizes, field positions, timing
`ifndef MCB_MAP_SVH
`define MCB_MAP_SVH
// ****************************************************************
// Sizes
// ****************************************************************
`define MCB_PORTS 64
`define MCB_PORT_W 6
`define MCB_ADDR_W 10
`define MCB_FEP_ADDR_W 7
`define MCB_WORD_W 16
`define MCB_DATA_WORDS 4
`define MCB_TX_OFFSET 7'h10
// ****************************************************************
// Block layout, bit counts after the sync periods (104 - 3 = 101)
// ****************************************************************
`define MCB_BLOCK_BITS 104
`define MCB_SYNC_PERIODS 2'd3
`define MCB_MSG_BITS 7'd101
`define MCB_POLL_END 7'd10
`define MCB_RXA_END 7'd26
`define MCB_DATA_END 7'd90
`define MCB_TX_PAD 21
// ****************************************************************
// Timing
// ****************************************************************
`define MCB_CLK_KHZ 40000
`define MCB_BIT_RATE_KHZ 2250
`define MCB_HALF_BIT_CYC ((`MCB_CLK_KHZ + 2 * `MCB_BIT_RATE_KHZ - 1) / (2 * `MCB_BIT_RATE_KHZ))
`endif

/* src/mcb_pkg.sv */
// Types and the address bank search of the multiport cable buffer
`include "mcb_map.svh"
package mcb_pkg;
  typedef logic [`MCB_PORT_W-1:0] mcb_port_t;
  typedef logic [`MCB_ADDR_W-1:0] mcb_addr_t;
  typedef logic [`MCB_WORD_W-1:0] mcb_word_t;
  typedef logic [`MCB_DATA_WORDS-1:0][`MCB_WORD_W-1:0] mcb_msg_t;
  typedef enum logic [2:0] {DN_IDLE = 3'h1, DN_DATA = 3'h2, DN_SETUP = 3'h4} mcb_dn_st_t;
  typedef enum logic [2:0] {TX_IDLE = 3'h1, TX_SYNC = 3'h2, TX_BITS = 3'h4} mcb_tx_st_t;
  typedef enum logic [1:0] {UP_IDLE = 2'h1, UP_SEND = 2'h2} mcb_up_st_t;

  // Returns {hit, index}; the lowest matching valid entry wins
  function automatic logic [6:0] mcb_find(input mcb_addr_t a,
                                          input logic [`MCB_PORTS-1:0][`MCB_ADDR_W-1:0] bank,
                                          input logic [`MCB_PORTS-1:0] valid);
    logic [6:0] res;
    res = 7'h00;
    for (int i = `MCB_PORTS - 1; i >= 0; i--) begin
      if (valid[i] && bank[i] == a) begin
        res = {1'b1, 6'(i)};
      end
    end
    return res;
  endfunction
endpackage

/* src/mcb_if.sv */
// DMA link between the buffer unit and the front-end processor
`timescale 1ns/10ps
`default_nettype none
interface mcb_if;
  logic dn_valid;
  logic dn_ready;
  logic dn_kind;
  logic dn_last;
  mcb_pkg::mcb_word_t dn_word;
  logic up_valid;
  logic up_ready;
  logic up_last;
  mcb_pkg::mcb_port_t up_port;
  mcb_pkg::mcb_word_t up_word;
  modport dev (output dn_valid, dn_kind, dn_last, dn_word, up_ready,
               input dn_ready, up_valid, up_last, up_port, up_word);
  modport fep (input dn_valid, dn_kind, dn_last, dn_word, up_ready,
               output dn_ready, up_valid, up_last, up_port, up_word);
endinterface
`default_nettype wire

/* src/mcb_sync.sv */
// Two-stage synchroniser with rising edge detect for modem pins
`timescale 1ns/10ps
`default_nettype none
module mcb_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);
  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
  } mcb_sync_st_t;
  mcb_sync_st_t r_reg, r_next;

  // Shift chain; only the second stage reads the first
  always_comb begin
    r_next = r_reg;
    r_next.ff1 = async_in;
    r_next.ff2 = r_reg.ff1;
    r_next.ff3 = r_reg.ff2;
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level_out = r_reg.ff2;
  assign rise_out = r_reg.ff2 & ~r_reg.ff3;
endmodule // mcb_sync
`default_nettype wire

/* src/mcb_buffer.sv */
// Buffer unit end: port banks, downstream match, upstream sender, DMA
`timescale 1ns/10ps
`default_nettype none
`include "mcb_map.svh"
// Operation
// - Hold 64 control words from call setup
// - Each control word has receive address register
// - Control word keeps terminal rate, code, format
// - Report control word and low 7 address bits
// - Controller reserves lowest 128 of 1024 addresses
// - Match receive address, capture data serially
// - Copy first input register into second
// - Send port word plus four words, one burst
// - DMA drains second register promptly, no stall
// - Upstream messages arrive from processor by DMA
// - 64 upstream data registers with transmit addresses
// - Each upstream payload is four 16-bit words
// - Transmit address equals receive address plus 16; processor end adds 16 to the low 7 bits modulo 128
// - Poll match selects port, shifts message upstream
// - Blocks are 104 bits at 2.25 Mbit/s; the sender uses 18 clocks per bit, about 2.22 Mbit/s at 40 MHz
// - Three sync periods; two pulses mark start
// - Poll field first, then control and address
// - Exactly four data words follow address match
module mcb_buffer #(
  parameter int HALF_BIT_CYC = `MCB_HALF_BIT_CYC
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  mcb_if.dev link,
  input wire logic setup_valid_in,
  output logic setup_ready_out,
  input wire mcb_pkg::mcb_port_t setup_port_in,
  input wire mcb_pkg::mcb_word_t setup_ctrl_in,
  input wire mcb_pkg::mcb_addr_t setup_addr_in,
  input wire logic ds_bclk_in,
  input wire logic ds_data_in,
  input wire logic ds_sync_in,
  output logic us_bclk_out,
  output logic us_data_out,
  output logic us_sync_out,
  output logic us_on_out
);
  import mcb_pkg::*;

  localparam logic [5:0] PH_HALF = 6'(HALF_BIT_CYC - 1);
  localparam logic [5:0] PH_LAST = 6'(2 * HALF_BIT_CYC - 1);
  localparam int TX_W = 101;

  typedef struct packed {
    logic [`MCB_PORTS-1:0][`MCB_WORD_W-1:0] ctrl;
    logic [`MCB_PORTS-1:0][`MCB_ADDR_W-1:0] rxa;
    logic [`MCB_PORTS-1:0] cfg;
    logic [`MCB_PORTS-1:0][`MCB_ADDR_W-1:0] txa;
    logic [`MCB_PORTS-1:0] txv;
    logic [`MCB_PORTS-1:0][`MCB_DATA_WORDS-1:0][`MCB_WORD_W-1:0] upd;
    logic setup_rdy;
    logic set_pend;
    mcb_port_t set_port;
    logic up_rdy;
    logic [2:0] up_cnt;
    logic rx_act;
    logic [1:0] sync_cnt;
    logic [6:0] rx_bit;
    logic [15:0] sh;
    logic rx_hit;
    mcb_port_t rx_idx;
    logic [63:0] in1;
    mcb_msg_t in2;
    mcb_port_t in2_port;
    logic in2_full;
    mcb_dn_st_t dn_st;
    logic [2:0] dn_cnt;
    logic dn_valid;
    logic dn_kind;
    logic dn_last;
    mcb_word_t dn_word;
    mcb_tx_st_t tx_st;
    logic [TX_W-1:0] tx_sh;
    logic [6:0] tx_bit;
    logic [5:0] tx_ph;
    logic [1:0] tx_per;
    logic us_bclk;
    logic us_data;
    logic us_sync;
    logic us_on;
  } mcb_buf_st_t;

  mcb_buf_st_t r_reg, r_next;
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [6:0] hit;

  // ****************************************************************
  // Modem pin synchroniser: bit 0 clock, bit 1 data, bit 2 sync
  // ****************************************************************
  mcb_sync #(.WIDTH(3)) u_sync (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .async_in({ds_sync_in, ds_data_in, ds_bclk_in}),
    .level_out(pin_lvl),
    .rise_out(pin_rise)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next = r_reg;
    hit = 7'h00;
    // Downstream DMA: data bursts before setup reports
    unique case (r_reg.dn_st)
      DN_IDLE: begin
        if (r_reg.in2_full) begin
          r_next.dn_st = DN_DATA;
          r_next.dn_valid = 1'b1;
          r_next.dn_kind = 1'b0;
          r_next.dn_cnt = 3'h0;
          r_next.dn_word = {10'h000, r_reg.in2_port};
        end else if (r_reg.set_pend) begin
          r_next.dn_st = DN_SETUP;
          r_next.dn_valid = 1'b1;
          r_next.dn_kind = 1'b1;
          r_next.dn_cnt = 3'h0;
          r_next.dn_word = {3'h0, r_reg.set_port, r_reg.rxa[r_reg.set_port][6:0]};
        end
      end
      DN_DATA: begin
        if (link.dn_ready) begin
          r_next.dn_cnt = r_reg.dn_cnt + 3'h1;
          if (r_reg.dn_last) begin
            r_next.dn_st = DN_IDLE;
            r_next.dn_valid = 1'b0;
            r_next.dn_last = 1'b0;
            r_next.in2_full = 1'b0;
          end else begin
            r_next.dn_word = r_reg.in2[2'(3'h3 - r_reg.dn_cnt)];
            r_next.dn_last = (r_reg.dn_cnt == 3'h3);
          end
        end
      end
      DN_SETUP: begin
        if (link.dn_ready) begin
          if (r_reg.dn_last) begin
            r_next.dn_st = DN_IDLE;
            r_next.dn_valid = 1'b0;
            r_next.dn_last = 1'b0;
            r_next.set_pend = 1'b0;
          end else begin
            r_next.dn_word = r_reg.ctrl[r_reg.set_port];
            r_next.dn_last = 1'b1;
          end
        end
      end
    endcase
    // Call setup writes a port's control word and receive address
    if (setup_valid_in && r_reg.setup_rdy) begin
      r_next.ctrl[setup_port_in] = setup_ctrl_in;
      r_next.rxa[setup_port_in] = setup_addr_in;
      r_next.cfg[setup_port_in] = 1'b1;
      r_next.set_pend = 1'b1;
      r_next.set_port = setup_port_in;
    end
    r_next.setup_rdy = !r_next.set_pend;
    // Upstream DMA: word 0 transmit address, words 1..4 payload
    r_next.up_rdy = 1'b1;
    if (link.up_valid && r_reg.up_rdy) begin
      if (r_reg.up_cnt == 3'h0) begin
        r_next.txa[link.up_port] = link.up_word[`MCB_ADDR_W-1:0];
        r_next.txv[link.up_port] = 1'b1;
      end else begin
        r_next.upd[link.up_port][2'(3'h4 - r_reg.up_cnt)] = link.up_word;
      end
      r_next.up_cnt = link.up_last ? 3'h0 : r_reg.up_cnt + 3'h1;
    end
    // Upstream sender: sync periods, then bits on the derived clock
    unique case (r_reg.tx_st)
      TX_IDLE: begin
      end
      TX_SYNC: begin
        r_next.tx_ph = r_reg.tx_ph + 6'h01;
        if (r_reg.tx_ph == PH_LAST) begin
          r_next.tx_ph = 6'h00;
          r_next.tx_per = r_reg.tx_per + 2'h1;
          if (r_reg.tx_per == `MCB_SYNC_PERIODS - 2'h1) begin
            r_next.tx_st = TX_BITS;
            r_next.us_data = r_reg.tx_sh[TX_W-1];
          end
        end
        // Two pulses, in the second and third periods
        r_next.us_sync = (r_next.tx_st == TX_SYNC) && (r_next.tx_per != 2'h0) &&
                         (r_next.tx_ph <= PH_HALF);
      end
      TX_BITS: begin
        r_next.tx_ph = r_reg.tx_ph + 6'h01;
        if (r_reg.tx_ph == PH_HALF) begin
          r_next.us_bclk = 1'b1;
        end
        if (r_reg.tx_ph == PH_LAST) begin
          r_next.tx_ph = 6'h00;
          r_next.us_bclk = 1'b0;
          r_next.tx_sh = {r_reg.tx_sh[TX_W-2:0], 1'b0};
          r_next.tx_bit = r_reg.tx_bit + 7'h01;
          if (r_reg.tx_bit == `MCB_MSG_BITS - 7'h01) begin
            r_next.tx_st = TX_IDLE;
            r_next.us_on = 1'b0;
            r_next.us_data = 1'b0;
          end else begin
            r_next.us_data = r_next.tx_sh[TX_W-1];
          end
        end
      end
    endcase
    // Downstream receive: two sync pulses open a block
    if (pin_rise[2]) begin
      if (r_reg.sync_cnt == 2'h1) begin
        r_next.rx_act = 1'b1;
        r_next.rx_bit = 7'h00;
        r_next.rx_hit = 1'b0;
        r_next.sync_cnt = 2'h0;
      end else begin
        r_next.sync_cnt = r_reg.sync_cnt + 2'h1;
      end
    end else if (pin_rise[0]) begin
      r_next.sync_cnt = 2'h0;
      if (r_reg.rx_act) begin
        r_next.sh = {r_reg.sh[14:0], pin_lvl[1]};
        r_next.rx_bit = r_reg.rx_bit + 7'h01;
        if (r_reg.rx_bit == `MCB_MSG_BITS - 7'h01) begin
          r_next.rx_act = 1'b0;
        end
        if (r_reg.rx_bit == `MCB_POLL_END - 7'h01) begin
          hit = mcb_find(r_next.sh[9:0], r_reg.txa, r_reg.txv);
          if (hit[6] && r_reg.tx_st == TX_IDLE) begin
            r_next.tx_st = TX_SYNC;
            r_next.tx_sh = {r_reg.txa[hit[5:0]], 6'h00, r_reg.upd[hit[5:0]],
                            {(`MCB_TX_PAD){1'b0}}};
            r_next.tx_ph = 6'h00;
            r_next.tx_per = 2'h0;
            r_next.tx_bit = 7'h00;
            r_next.us_on = 1'b1;
          end
        end
        if (r_reg.rx_bit == `MCB_RXA_END - 7'h01) begin
          hit = mcb_find(r_next.sh[9:0], r_reg.rxa, r_reg.cfg);
          r_next.rx_hit = hit[6];
          r_next.rx_idx = hit[5:0];
        end
        if (r_reg.rx_hit && r_reg.rx_bit >= `MCB_RXA_END && r_reg.rx_bit < `MCB_DATA_END) begin
          r_next.in1 = {r_reg.in1[62:0], pin_lvl[1]};
        end
        if (r_reg.rx_hit && r_reg.rx_bit == `MCB_DATA_END - 7'h01) begin
          r_next.in2 = r_next.in1;
          r_next.in2_port = r_reg.rx_idx;
          r_next.in2_full = 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      r_reg <= '0;
      r_reg.dn_st <= DN_IDLE;
      r_reg.tx_st <= TX_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign setup_ready_out = r_reg.setup_rdy;
  assign link.dn_valid = r_reg.dn_valid;
  assign link.dn_kind = r_reg.dn_kind;
  assign link.dn_last = r_reg.dn_last;
  assign link.dn_word = r_reg.dn_word;
  assign link.up_ready = r_reg.up_rdy;
  assign us_bclk_out = r_reg.us_bclk;
  assign us_data_out = r_reg.us_data;
  assign us_sync_out = r_reg.us_sync;
  assign us_on_out = r_reg.us_on;
endmodule // mcb_buffer
`default_nettype wire

/* src/mcb_fep.sv */
// Front-end processor end: takes reports and data, sends upstream messages
`timescale 1ns/10ps
`default_nettype none
`include "mcb_map.svh"
module mcb_fep (
  input wire logic clock_in,
  input wire logic rstn_in,
  mcb_if.fep link,
  output logic rep_valid_out,
  output logic rep_kind_out,
  output mcb_pkg::mcb_port_t rep_port_out,
  output mcb_pkg::mcb_word_t rep_ctrl_out,
  output logic [`MCB_FEP_ADDR_W-1:0] rep_addr_out,
  output mcb_pkg::mcb_msg_t rep_data_out,
  input wire logic msg_valid_in,
  output logic msg_ready_out,
  input wire mcb_pkg::mcb_port_t msg_port_in,
  input wire mcb_pkg::mcb_msg_t msg_data_in
);
  import mcb_pkg::*;

  typedef struct packed {
    logic [`MCB_PORTS-1:0][`MCB_FEP_ADDR_W-1:0] rx7;
    logic dn_rdy;
    logic [2:0] dn_cnt;
    logic rep_valid;
    logic rep_kind;
    mcb_port_t rep_port;
    mcb_word_t rep_ctrl;
    logic [`MCB_FEP_ADDR_W-1:0] rep_addr;
    mcb_msg_t rep_data;
    mcb_up_st_t up_st;
    logic msg_rdy;
    mcb_msg_t msg;
    logic [2:0] up_cnt;
    logic up_valid;
    logic up_last;
    mcb_port_t up_port;
    mcb_word_t up_word;
  } mcb_fep_st_t;

  mcb_fep_st_t r_reg, r_next;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next = r_reg;
    r_next.rep_valid = 1'b0;
    // Always ready, so the buffer's second register drains at once
    r_next.dn_rdy = 1'b1;
    if (link.dn_valid && r_reg.dn_rdy) begin
      r_next.dn_cnt = link.dn_last ? 3'h0 : r_reg.dn_cnt + 3'h1;
      if (link.dn_kind) begin
        if (r_reg.dn_cnt == 3'h0) begin
          r_next.rep_port = link.dn_word[12:7];
          r_next.rep_addr = link.dn_word[6:0];
          r_next.rx7[link.dn_word[12:7]] = link.dn_word[6:0];
        end else begin
          r_next.rep_ctrl = link.dn_word;
        end
      end else if (r_reg.dn_cnt == 3'h0) begin
        r_next.rep_port = link.dn_word[5:0];
      end else begin
        r_next.rep_data = {r_reg.rep_data[2:0], link.dn_word};
      end
      if (link.dn_last) begin
        r_next.rep_valid = 1'b1;
        r_next.rep_kind = link.dn_kind;
      end
    end
    // Upstream burst: transmit address, then four payload words
    unique case (r_reg.up_st)
      UP_IDLE: begin
        if (msg_valid_in && r_reg.msg_rdy) begin
          r_next.up_st = UP_SEND;
          r_next.msg = msg_data_in;
          r_next.up_port = msg_port_in;
          r_next.up_cnt = 3'h0;
          r_next.up_valid = 1'b1;
          r_next.up_last = 1'b0;
          // High address bits stay zero inside the reserved low block
          r_next.up_word = {9'h000, 7'(r_reg.rx7[msg_port_in] + `MCB_TX_OFFSET)};
        end
      end
      UP_SEND: begin
        if (link.up_ready) begin
          r_next.up_cnt = r_reg.up_cnt + 3'h1;
          if (r_reg.up_last) begin
            r_next.up_st = UP_IDLE;
            r_next.up_valid = 1'b0;
            r_next.up_last = 1'b0;
          end else begin
            r_next.up_word = r_reg.msg[2'(3'h3 - r_reg.up_cnt)];
            r_next.up_last = (r_reg.up_cnt == 3'h3);
          end
        end
      end
    endcase
    r_next.msg_rdy = (r_next.up_st == UP_IDLE);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      r_reg <= '0;
      r_reg.up_st <= UP_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign link.dn_ready = r_reg.dn_rdy;
  assign link.up_valid = r_reg.up_valid;
  assign link.up_last = r_reg.up_last;
  assign link.up_port = r_reg.up_port;
  assign link.up_word = r_reg.up_word;
  assign rep_valid_out = r_reg.rep_valid;
  assign rep_kind_out = r_reg.rep_kind;
  assign rep_port_out = r_reg.rep_port;
  assign rep_ctrl_out = r_reg.rep_ctrl;
  assign rep_addr_out = r_reg.rep_addr;
  assign rep_data_out = r_reg.rep_data;
  assign msg_ready_out = r_reg.msg_rdy;
endmodule // mcb_fep
`default_nettype wire

/* verification/mcb_link_chk.sv */
// Assertions on the DMA link between the buffer unit and the processor end
`timescale 1ns/10ps
`default_nettype none
module mcb_link_chk (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic dn_valid,
  input wire logic dn_ready,
  input wire logic dn_kind,
  input wire logic dn_last,
  input wire mcb_pkg::mcb_word_t dn_word,
  input wire logic up_valid,
  input wire logic up_ready,
  input wire logic up_last,
  input wire mcb_pkg::mcb_port_t up_port,
  input wire mcb_pkg::mcb_word_t up_word
);
  import mcb_pkg::*;
  // ********
  // Link properties
  // ********
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  chk_dn_prompt: assert property (dn_valid |-> dn_ready)
    else $error("downstream word stalled");
  chk_setup_burst: assert property ($rose(dn_valid) && dn_kind |-> dn_word[15:13] == 3'h0
    && !dn_last ##1 dn_valid && dn_kind && dn_last ##1 !dn_valid)
    else $error("setup report burst malformed");
  chk_data_burst: assert property ($rose(dn_valid) && !dn_kind |->
    dn_word[15:6] == 10'h000 && !dn_last
    ##1 (dn_valid && !dn_kind && !dn_last)[*3] ##1 dn_valid && dn_last ##1 !dn_valid)
    else $error("data burst is not port word plus four");
  chk_up_burst: assert property ($rose(up_valid) |-> up_word[15:7] == 9'h000 && !up_last
    ##1 (up_valid && !up_last)[*3] ##1 up_valid && up_last ##1 !up_valid)
    else $error("upstream burst malformed");
  chk_up_port: assert property (up_valid && !up_last |=> $stable(up_port))
    else $error("upstream port changed in burst");
  chk_dn_last: assert property (dn_last |-> dn_valid)
    else $error("last flag outside a burst");
  chk_up_ready: assert property ($past(rstn_in) |-> up_ready)
    else $error("upstream side not ready");
  chk_kind_hold: assert property (dn_valid && !dn_last |=> dn_valid && $stable(dn_kind))
    else $error("burst broken or kind changed");
endmodule // mcb_link_chk
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench: both ends of the buffer link with modem stimulus
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mcb_pkg::*;
  typedef struct {logic kind; mcb_port_t port; mcb_word_t ctrl; logic [6:0] addr;
    mcb_msg_t data;} mcb_exp_t;
  localparam mcb_port_t ports[4] = '{6'h00, 6'h3f, 6'h11, 6'h2a};
  localparam logic [6:0] rx7_tab[4] = '{7'h03, 7'h23, 7'h43, 7'h75};
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic setup_valid_in, setup_ready_out, ds_bclk_in, ds_data_in, ds_sync_in;
  logic us_bclk_out, us_data_out, us_sync_out, us_on_out;
  logic msg_valid_in, msg_ready_out, rep_valid_out, rep_kind_out;
  mcb_port_t setup_port_in, msg_port_in, rep_port_out;
  mcb_word_t setup_ctrl_in, rep_ctrl_out;
  mcb_addr_t setup_addr_in;
  logic [6:0] rep_addr_out;
  mcb_msg_t msg_data_in, rep_data_out;
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 32'h8f320b5f;
  int us_n = 0;
  int us_syn = 0;
  logic us_bclk_d = 1'b0;
  logic us_sync_d = 1'b0;
  logic us_on_d = 1'b0;
  logic [100:0] us_bits;
  mcb_exp_t e;
  mcb_exp_t rep_q[$];
  logic [100:0] us_q[$];
  // ********
  // Design ends and checker
  // ********
  mcb_if u_mcb_if ();
  mcb_buffer u_mcb_buffer (.clock_in(clock_in), .rstn_in(rstn_in), .link(u_mcb_if.dev),
    .setup_valid_in(setup_valid_in), .setup_ready_out(setup_ready_out),
    .setup_port_in(setup_port_in), .setup_ctrl_in(setup_ctrl_in), .setup_addr_in(setup_addr_in),
    .ds_bclk_in(ds_bclk_in), .ds_data_in(ds_data_in), .ds_sync_in(ds_sync_in),
    .us_bclk_out(us_bclk_out), .us_data_out(us_data_out), .us_sync_out(us_sync_out),
    .us_on_out(us_on_out));
  mcb_fep u_mcb_fep (.clock_in(clock_in), .rstn_in(rstn_in), .link(u_mcb_if.fep),
    .rep_valid_out(rep_valid_out), .rep_kind_out(rep_kind_out), .rep_port_out(rep_port_out),
    .rep_ctrl_out(rep_ctrl_out), .rep_addr_out(rep_addr_out), .rep_data_out(rep_data_out),
    .msg_valid_in(msg_valid_in), .msg_ready_out(msg_ready_out), .msg_port_in(msg_port_in),
    .msg_data_in(msg_data_in));
  mcb_link_chk u_chk (.clock_in(clock_in), .rstn_in(rstn_in), .dn_valid(u_mcb_if.dn_valid),
    .dn_ready(u_mcb_if.dn_ready), .dn_kind(u_mcb_if.dn_kind), .dn_last(u_mcb_if.dn_last),
    .dn_word(u_mcb_if.dn_word), .up_valid(u_mcb_if.up_valid), .up_ready(u_mcb_if.up_ready),
    .up_last(u_mcb_if.up_last), .up_port(u_mcb_if.up_port), .up_word(u_mcb_if.up_word));
  // ********
  // Shared tasks
  // ********
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR at %0t: %s", $time, what);
    end
  endtask
  // Waits a few edges, then drives just after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask
  // Bounded wait for a level seen at a clock edge
  task automatic await(ref logic r, input logic lvl, input int lim);
    int k;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (r !== lvl && k < lim);
    if (r !== lvl) begin
      n_mismatch++;
      $display("ERROR at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  // One setup write, held until taken
  task automatic do_setup(input mcb_port_t p, input mcb_addr_t a);
    mcb_word_t c;
    c = 16'($random(seed));
    setup_valid_in = 1'b1;
    setup_port_in = p;
    setup_ctrl_in = c;
    setup_addr_in = a;
    rep_q.push_back('{1'b1, p, c, a[6:0], 64'h0});
    await(setup_ready_out, 1'b1, 200);
    #2;
    setup_valid_in = 1'b0;
    tick(1);
  endtask
  // One upstream message from the processor side
  task automatic load_msg(input mcb_port_t p, input logic [6:0] rx7, input mcb_msg_t d);
    msg_valid_in = 1'b1;
    msg_port_in = p;
    msg_data_in = d;
    us_q.push_back({3'h0, 7'(rx7 + 7'h10), 6'h00, d, 21'h0});
    await(msg_ready_out, 1'b1, 200);
    #2;
    msg_valid_in = 1'b0;
    tick(1);
  endtask
  // Modem block: three sync periods, then 101 bits of 8 cycles each
  task automatic send_block(input mcb_addr_t poll, input mcb_addr_t rxa, input mcb_msg_t d);
    logic [100:0] b;
    b = {poll, 6'h00, rxa, d, 11'h000};
    tick(8);
    repeat (2) begin
      ds_sync_in = 1'b1;
      tick(4);
      ds_sync_in = 1'b0;
      tick(4);
    end
    for (int i = 100; i >= 0; i--) begin
      ds_data_in = b[i];
      tick(4);
      ds_bclk_in = 1'b1;
      tick(4);
      ds_bclk_in = 1'b0;
    end
    ds_data_in = ~ds_data_in; // Idle line never repeats the last bit
  endtask
  // ********
  // Result monitors
  // ********
  // Compare each processor report with the oldest note
  always @(posedge clock_in) begin
    if (rstn_in && rep_valid_out === 1'b1) begin
      if (rep_q.size() == 0) check(1'b0, "report with no note");
      else begin
        e = rep_q.pop_front();
        check(rep_kind_out === e.kind && rep_port_out === e.port, "report kind/port");
        if (e.kind) check(rep_ctrl_out === e.ctrl, "setup control word");
        if (e.kind) check(rep_addr_out === e.addr, "setup address");
        else check(rep_data_out === e.data, "data report");
      end
    end
  end
  // Collect upstream blocks and compare at their end
  always @(posedge clock_in) begin
    if (us_on_out === 1'b1) begin
      if (us_bclk_out && !us_bclk_d) begin
        us_bits = {us_bits[99:0], us_data_out};
        us_n++;
      end
      if (us_sync_out && !us_sync_d) us_syn++;
    end else if (us_on_d === 1'b1) begin
      check(us_n == 101 && us_syn == 2, "upstream framing");
      if (us_q.size() == 0) check(1'b0, "upstream block with no note");
      else check(us_bits === us_q.pop_front(), "upstream bits");
      us_n = 0;
      us_syn = 0;
    end
    us_bclk_d = us_bclk_out;
    us_sync_d = us_sync_out;
    us_on_d = us_on_out;
  end
  // ********
  // Clock, watchdog and main sequence
  // ********
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end
  initial begin
    repeat (100000) @(posedge clock_in);
    n_mismatch++;
    $display("ERROR at %0t: run timed out", $time);
    give_verdict();
  end
  initial begin
    mcb_addr_t rxa[4];
    mcb_msg_t d;
    setup_valid_in = 1'b0;
    setup_port_in = 6'h00;
    setup_ctrl_in = 16'h0000;
    setup_addr_in = 10'h000;
    msg_valid_in = 1'b0;
    msg_port_in = 6'h00;
    msg_data_in = 64'h0;
    ds_bclk_in = 1'b0;
    ds_data_in = 1'b0;
    ds_sync_in = 1'b0;
    tick(6);
    rstn_in = 1'b1;
    tick(1);
    for (int i = 0; i < 4; i++) begin
      // Receive addresses stay inside the low block reserved for this unit
      rxa[i] = {3'h0, rx7_tab[i]};
      do_setup(ports[i], rxa[i]);
    end
    for (int i = 0; i < 4; i++) begin
      d = {$random(seed), $random(seed)};
      rep_q.push_back('{1'b0, ports[i], 16'h0, 7'h0, d});
      send_block(10'h3ff, rxa[i], d);
      if (i == 1) send_block(10'h3ff, 10'h3ff, ~d);
    end
    for (int i = 0; i < 4; i += 3) begin
      d = {$random(seed), $random(seed)};
      load_msg(ports[i], rx7_tab[i], d);
    end
    for (int i = 0; i < 4; i += 3) begin
      send_block({3'h0, 7'(rx7_tab[i] + 7'h10)}, 10'h3ff, 64'h0);
      await(us_on_out, 1'b0, 4000);
    end
    tick(400);
    check(rep_q.size() == 0 && us_q.size() == 0, "results missing");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
